// File: rtl/asl_top.sv
// Notes on behaviour
// - Link enable zero halts link machine
// - Calibration enable zero halts calibration machine
// - Calibration enable one starts calibration machine in background mode; otherwise it waits for a trigger edge
// - Link enable one restarts link machine
// - Link states follow receiver sync request
// - Zero-to-one on trigger launches calibration
//
// The register offsets and the AXI4-Lite slave port are this design's own decisions.
module asl_top
    import asl_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // AXI4-Lite write address
    input wire logic [11:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    // AXI4-Lite read address
    input wire logic [11:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    // Sync request pins, active low on the wire
    input wire logic sync_se_n_in,
    input wire logic sync_ts_n_in,
    // Status
    output logic link_up_out,
    output logic cal_busy_out,
    output logic overrange_enable_out
);
    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic [1:0] se_meta, se_sync;
    logic [1:0] next_se_sync;

    // Both sync pins come from the receiver's domain
    always_comb begin
        next_se_sync = {sync_ts_n_in, sync_se_n_in};
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            se_meta <= 2'b11;
            se_sync <= 2'b11;
        end else begin
            se_meta <= next_se_sync;
            se_sync <= se_meta;
        end
    end

    // ****************************************
    // Register state
    // ****************************************
    logic link_en, next_link_en;
    logic cal_en, next_cal_en;
    asl_link_cfg_t link_cfg, next_link_cfg;
    logic cal_bg, next_cal_bg;
    logic cal_ofs, next_cal_ofs;
    logic overrange_detect_enable, next_overrange_detect_enable;
    logic [7:0] ovr_thr, next_ovr_thr;
    logic cal_trig, next_cal_trig;
    logic [5:0] srst_cnt, next_srst_cnt;
    logic srst_active;

    // ****************************************
    // AXI4-Lite slave
    // ****************************************
    logic aw_held, next_aw_held;
    logic w_held, next_w_held;
    logic [11:0] aw_addr, next_aw_addr;
    logic [31:0] w_data, next_w_data;
    logic [3:0] w_strb, next_w_strb;
    logic bvalid, next_bvalid;
    logic [1:0] bresp, next_bresp;
    logic rvalid, next_rvalid;
    logic [31:0] rdata, next_rdata;
    logic [1:0] rresp, next_rresp;
    logic do_write;
    asl_link_state_t lnk_state;
    asl_cal_state_t cal_state;
    logic cal_busy;
    logic [7:0] lnk_frame;

    function automatic logic mapped(input logic [11:0] a);
        mapped = (a[1:0] == 2'b00) && (a <= ASL_OFF_STATUS);
    endfunction

    assign s_axi_awready_out = !aw_held && !bvalid;
    assign s_axi_wready_out = !w_held && !bvalid;
    assign s_axi_arready_out = !rvalid;
    assign do_write = (aw_held || s_axi_awvalid_in) && (w_held || s_axi_wvalid_in) && !bvalid;

    always_comb begin
        logic [11:0] wa;
        logic [31:0] wd;
        logic [3:0] ws;
        wa = aw_held ? aw_addr : s_axi_awaddr_in;
        wd = w_held ? w_data : s_axi_wdata_in;
        ws = w_held ? w_strb : s_axi_wstrb_in;
        next_aw_held = aw_held;
        next_w_held = w_held;
        next_aw_addr = aw_addr;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = bvalid && !s_axi_bready_in;
        next_bresp = bresp;
        next_link_en = link_en;
        next_cal_en = cal_en;
        next_link_cfg = link_cfg;
        next_cal_bg = cal_bg;
        next_cal_ofs = cal_ofs;
        next_overrange_detect_enable = overrange_detect_enable;
        next_ovr_thr = ovr_thr;
        next_cal_trig = cal_trig;
        next_srst_cnt = (srst_cnt != 6'h00) ? srst_cnt - 6'h01 : 6'h00;
        if (s_axi_awvalid_in && s_axi_awready_out) begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr_in;
        end
        if (s_axi_wvalid_in && s_axi_wready_out) begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata_in;
            next_w_strb = s_axi_wstrb_in;
        end
        if (do_write) begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = mapped(wa) ? 2'b00 : 2'b10;
            // Writes during the reset wait are accepted but dropped
            if (!srst_active) begin
                unique case (wa)
                    ASL_OFF_RESET: begin
                        if (ws[0] && wd[0]) begin
                            next_srst_cnt = 6'(ASL_SRST_CYC);
                            next_link_en = ASL_LINK_EN_RST;
                            next_cal_en = ASL_CAL_EN_RST;
                            next_link_cfg = '{ASL_MODE_RST, ASL_KM1_RST, 1'b0};
                            next_cal_bg = 1'b0;
                            next_cal_ofs = 1'b0;
                            next_overrange_detect_enable = 1'b0;
                            next_ovr_thr = 8'h00;
                            next_cal_trig = 1'b0;
                        end
                    end
                    ASL_OFF_LINK_EN: if (ws[0]) next_link_en = wd[0];
                    ASL_OFF_CAL_EN: if (ws[0]) next_cal_en = wd[0];
                    ASL_OFF_LINK_CFG: begin
                        // Link settings only change while the link machine is halted
                        if (!link_en) begin
                            if (ws[0]) next_link_cfg.link_format_mode = wd[ASL_MODE_W-1:0];
                            if (ws[1]) begin
                                next_link_cfg.multiframe_length_field =
                                    wd[ASL_KM1_LSB +: ASL_KM1_W];
                            end
                            if (ws[2]) next_link_cfg.sync_from_timestamp = wd[ASL_SYNC_SEL_BIT];
                        end
                    end
                    ASL_OFF_CAL_CFG: begin
                        if (!cal_en && ws[0]) begin
                            next_cal_bg = wd[ASL_CAL_BG_BIT];
                            next_cal_ofs = wd[ASL_CAL_OFS_BIT];
                        end
                    end
                    ASL_OFF_OVR_CFG: begin
                        if (ws[0]) next_overrange_detect_enable = wd[ASL_OVERRANGE_DETECT_ENABLE_BIT];
                        if (ws[1]) next_ovr_thr = wd[ASL_OVR_THR_LSB +: ASL_OVR_THR_W];
                    end
                    ASL_OFF_CAL_TRIG: if (ws[0]) next_cal_trig = wd[0];
                    default: begin
                    end
                endcase
            end
        end
    end

    always_comb begin
        next_rvalid = rvalid && !s_axi_rready_in;
        next_rdata = rdata;
        next_rresp = rresp;
        if (s_axi_arvalid_in && s_axi_arready_out) begin
            next_rvalid = 1'b1;
            next_rresp = mapped(s_axi_araddr_in) ? 2'b00 : 2'b10;
            next_rdata = 32'h0000_0000;
            unique case (s_axi_araddr_in)
                ASL_OFF_RESET: next_rdata[0] = srst_active;
                ASL_OFF_LINK_EN: next_rdata[0] = link_en;
                ASL_OFF_CAL_EN: next_rdata[0] = cal_en;
                ASL_OFF_LINK_CFG: begin
                    next_rdata[ASL_MODE_W-1:0] = link_cfg.link_format_mode;
                    next_rdata[ASL_KM1_LSB +: ASL_KM1_W] = link_cfg.multiframe_length_field;
                    next_rdata[ASL_SYNC_SEL_BIT] = link_cfg.sync_from_timestamp;
                end
                ASL_OFF_CAL_CFG: begin
                    next_rdata[ASL_CAL_BG_BIT] = cal_bg;
                    next_rdata[ASL_CAL_OFS_BIT] = cal_ofs;
                end
                ASL_OFF_OVR_CFG: begin
                    next_rdata[ASL_OVERRANGE_DETECT_ENABLE_BIT] = overrange_detect_enable;
                    next_rdata[ASL_OVR_THR_LSB +: ASL_OVR_THR_W] = ovr_thr;
                end
                ASL_OFF_CAL_TRIG: next_rdata[0] = cal_trig;
                ASL_OFF_STATUS: next_rdata = {8'h00, lnk_frame, 11'h000, cal_busy,
                    cal_state, lnk_state};
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 12'h000;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            bvalid <= 1'b0;
            bresp <= 2'b00;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= 2'b00;
            link_en <= ASL_LINK_EN_RST;
            cal_en <= ASL_CAL_EN_RST;
            link_cfg <= '{ASL_MODE_RST, ASL_KM1_RST, 1'b0};
            cal_bg <= 1'b0;
            cal_ofs <= 1'b0;
            overrange_detect_enable <= 1'b0;
            ovr_thr <= 8'h00;
            cal_trig <= 1'b0;
            srst_cnt <= 6'h00;
        end else begin
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            aw_addr <= next_aw_addr;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
            rvalid <= next_rvalid;
            rdata <= next_rdata;
            rresp <= next_rresp;
            link_en <= next_link_en;
            cal_en <= next_cal_en;
            link_cfg <= next_link_cfg;
            cal_bg <= next_cal_bg;
            cal_ofs <= next_cal_ofs;
            overrange_detect_enable <= next_overrange_detect_enable;
            ovr_thr <= next_ovr_thr;
            cal_trig <= next_cal_trig;
            srst_cnt <= next_srst_cnt;
        end
    end

    assign srst_active = (srst_cnt != 6'h00);
    assign s_axi_bvalid_out = bvalid;
    assign s_axi_bresp_out = bresp;
    assign s_axi_rvalid_out = rvalid;
    assign s_axi_rdata_out = rdata;
    assign s_axi_rresp_out = rresp;

    // ****************************************
    // State machines
    // ****************************************
    logic sync_req;

    // Sync source chosen by configuration; pins are active low
    assign sync_req = link_cfg.sync_from_timestamp ? !se_sync[1] : !se_sync[0];

    asl_link_fsm u_link (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .enable_in(link_en && !srst_active),
        .cfg_in(link_cfg),
        .sync_req_in(sync_req),
        .state_out(lnk_state),
        .frame_out(lnk_frame)
    );

    asl_cal_fsm u_cal (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .enable_in(cal_en && !srst_active),
        .background_in(cal_bg),
        .trig_in(cal_trig),
        .state_out(cal_state),
        .busy_out(cal_busy)
    );

    assign link_up_out = (lnk_state == ASL_LNK_DATA);
    assign cal_busy_out = cal_busy;
    assign overrange_enable_out = overrange_detect_enable;
endmodule

// File: rtl/asl_pkg.sv
package asl_pkg;
    // ****************************************
    // Register byte offsets
    // ****************************************
    localparam logic [11:0] ASL_OFF_RESET = 12'h000;
    localparam logic [11:0] ASL_OFF_LINK_EN = 12'h004;
    localparam logic [11:0] ASL_OFF_CAL_EN = 12'h008;
    localparam logic [11:0] ASL_OFF_LINK_CFG = 12'h00c;
    localparam logic [11:0] ASL_OFF_CAL_CFG = 12'h010;
    localparam logic [11:0] ASL_OFF_OVR_CFG = 12'h014;
    localparam logic [11:0] ASL_OFF_CAL_TRIG = 12'h018;
    localparam logic [11:0] ASL_OFF_STATUS = 12'h01c;

    // ****************************************
    // Field positions and widths
    // ****************************************
    localparam int ASL_MODE_W = 5;
    localparam int ASL_KM1_W = 8;
    localparam int ASL_KM1_LSB = 8;
    localparam int ASL_SYNC_SEL_BIT = 16;
    localparam int ASL_CAL_BG_BIT = 0;
    localparam int ASL_CAL_OFS_BIT = 1;
    localparam int ASL_OVERRANGE_DETECT_ENABLE_BIT = 0;
    localparam int ASL_OVR_THR_LSB = 8;
    localparam int ASL_OVR_THR_W = 8;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic ASL_LINK_EN_RST = 1'b1;
    localparam logic ASL_CAL_EN_RST = 1'b1;
    localparam logic [4:0] ASL_MODE_RST = 5'h00;
    localparam logic [7:0] ASL_KM1_RST = 8'h1f;

    // ****************************************
    // Timing
    // ****************************************
    localparam int ASL_CLK_MHZ = 50;
    localparam int ASL_SRST_WAIT_NS = 1000;
    localparam int ASL_SRST_CYC = (ASL_SRST_WAIT_NS * ASL_CLK_MHZ + 999) / 1000;
    localparam int ASL_CAL_CYC = 64;
    localparam int ASL_ILA_FRAMES_PER_CNT = 4;

    // ****************************************
    // Types
    // ****************************************
    typedef struct packed {
        logic [4:0] link_format_mode;
        logic [7:0] multiframe_length_field;
        logic sync_from_timestamp;
    } asl_link_cfg_t;

    typedef enum logic [1:0] {
        ASL_LNK_HALT = 2'b00,
        ASL_LNK_CGS = 2'b01,
        ASL_LNK_ILA = 2'b11,
        ASL_LNK_DATA = 2'b10
    } asl_link_state_t;

    typedef enum logic [1:0] {
        ASL_CAL_IDLE = 2'b00,
        ASL_CAL_RUN = 2'b01,
        ASL_CAL_DONE = 2'b11
    } asl_cal_state_t;
endpackage

// File: rtl/asl_link_fsm.sv
module asl_link_fsm
    import asl_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // Control
    input wire logic enable_in,
    input wire asl_link_cfg_t cfg_in,
    input wire logic sync_req_in,
    // Status
    output asl_link_state_t state_out,
    output logic [7:0] frame_out
);
    // ****************************************
    // Link state machine
    // ****************************************
    asl_link_state_t state, next_state;
    logic [7:0] frame, next_frame;
    logic [1:0] ila_mf, next_ila_mf;

    always_comb begin
        next_state = state;
        next_frame = frame;
        next_ila_mf = ila_mf;
        if (!enable_in) begin
            next_state = ASL_LNK_HALT;
            next_frame = 8'h00;
            next_ila_mf = 2'h0;
        end else begin
            next_frame = (frame == cfg_in.multiframe_length_field) ? 8'h00 : frame + 8'h01;
            unique case (state)
                ASL_LNK_HALT: begin
                    next_state = ASL_LNK_CGS;
                    next_frame = 8'h00;
                end
                ASL_LNK_CGS: begin
                    if (!sync_req_in) begin
                        next_state = ASL_LNK_ILA;
                        next_frame = 8'h00;
                        next_ila_mf = 2'h0;
                    end
                end
                ASL_LNK_ILA: begin
                    if (sync_req_in) begin
                        next_state = ASL_LNK_CGS;
                    end else if (frame == cfg_in.multiframe_length_field) begin
                        next_ila_mf = ila_mf + 2'h1;
                        if (ila_mf == 2'(ASL_ILA_FRAMES_PER_CNT - 1)) begin
                            next_state = ASL_LNK_DATA;
                        end
                    end
                end
                ASL_LNK_DATA: begin
                    if (sync_req_in) begin
                        next_state = ASL_LNK_CGS;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            state <= ASL_LNK_HALT;
            frame <= 8'h00;
            ila_mf <= 2'h0;
        end else begin
            state <= next_state;
            frame <= next_frame;
            ila_mf <= next_ila_mf;
        end
    end

    assign state_out = state;
    assign frame_out = frame;
endmodule

// File: rtl/asl_cal_fsm.sv
module asl_cal_fsm
    import asl_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // Control
    input wire logic enable_in,
    input wire logic background_in,
    input wire logic trig_in,
    // Status
    output asl_cal_state_t state_out,
    output logic busy_out
);
    // ****************************************
    // Calibration state machine
    // ****************************************
    asl_cal_state_t state, next_state;
    logic [6:0] cnt, next_cnt;
    logic trig_d, next_trig_d;
    logic launch;

    // The trigger launches only on a rising edge; a level held at one does not retrigger
    assign launch = trig_in && !trig_d;

    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_trig_d = trig_in;
        if (!enable_in) begin
            next_state = ASL_CAL_IDLE;
            next_cnt = 7'h00;
        end else begin
            unique case (state)
                ASL_CAL_IDLE, ASL_CAL_DONE: begin
                    if (launch || (background_in && state == ASL_CAL_IDLE)) begin
                        next_state = ASL_CAL_RUN;
                        next_cnt = 7'h00;
                    end
                end
                ASL_CAL_RUN: begin
                    next_cnt = cnt + 7'h01;
                    if (cnt == 7'(ASL_CAL_CYC - 1)) begin
                        next_state = background_in ? ASL_CAL_IDLE : ASL_CAL_DONE;
                    end
                end
                default: next_state = ASL_CAL_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            state <= ASL_CAL_IDLE;
            cnt <= 7'h00;
            trig_d <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            trig_d <= next_trig_d;
        end
    end

    assign state_out = state;
    assign busy_out = (state == ASL_CAL_RUN);
endmodule

// File: test/asl_monitor.sv
module asl_monitor
    import asl_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // Register bus
    input wire logic s_axi_awvalid_in,
    input wire logic s_axi_awready_out,
    input wire logic s_axi_wvalid_in,
    input wire logic s_axi_wready_out,
    input wire logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic [11:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    input wire logic s_axi_arready_out,
    input wire logic s_axi_rvalid_out,
    input wire logic [1:0] s_axi_rresp_out,
    input wire logic s_axi_rready_in,
    // Sync pins and status
    input wire logic sync_se_n_in,
    input wire logic sync_ts_n_in,
    input wire logic link_up_out,
    input wire logic cal_busy_out,
    input wire logic overrange_enable_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);

    bvalid_hold_a: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out)
        else $error("write response dropped early");
    rvalid_hold_a: assert property (s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out)
        else $error("read data dropped early");
    write_answer_a: assert property (s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in
        && s_axi_wready_out |=> s_axi_bvalid_out) else $error("write not answered");
    read_answer_a: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
        else $error("read not answered");
    read_block_a: assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
        else $error("read taken while answer pending");
    unmapped_read_a: assert property (s_axi_arvalid_in && s_axi_arready_out
        && (s_axi_araddr_in > 12'h01c || s_axi_araddr_in[1:0] != 2'h0)
        |=> s_axi_rresp_out == 2'h2) else $error("unmapped read not refused");
    reset_clear_a: assert property (disable iff (1'b0) sys_rst_in
        |=> !link_up_out && !cal_busy_out && !overrange_enable_out) else $error("reset values");
    sync_resync_a: assert property ((!sync_se_n_in && !sync_ts_n_in) [*5] |=> !link_up_out)
        else $error("link stayed up under sync request");
    link_needs_sync_a: assert property ($rose(link_up_out)
        |-> $past(sync_se_n_in, 3) || $past(sync_ts_n_in, 3)) else $error("link up without sync");
    cal_run_a: assert property ($rose(cal_busy_out) |-> cal_busy_out [*8])
        else $error("calibration run cut short");

    link_up_c: cover property ($rose(link_up_out));
    cal_run_c: cover property ($rose(cal_busy_out));
    refused_c: cover property (s_axi_rvalid_out && s_axi_rresp_out == 2'h2);
endmodule

bind asl_top asl_monitor u_mon (.*);

// File: test/asl_rx_model.sv
module asl_rx_model (
    // Clock and reset
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // Resync command per pin, bit 0 single-ended, bit 1 timestamp
    input wire logic [1:0] resync_in,
    // Sync request pins, low asks for code group sync
    output logic sync_se_n_out,
    output logic sync_ts_n_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] se_cnt;
    logic [3:0] ts_cnt;
    // Receiver requests sync for a while after reset or a command
    always_ff @(posedge clk_in) begin
        se_cnt <= (sys_rst_in || resync_in[0]) ? 4'h8 : se_cnt - {3'h0, se_cnt != 4'h0};
        ts_cnt <= (sys_rst_in || resync_in[1]) ? 4'h8 : ts_cnt - {3'h0, ts_cnt != 4'h0};
    end
    assign sync_se_n_out = (se_cnt == 4'h0);
    assign sync_ts_n_out = (ts_cnt == 4'h0);
endmodule

// File: test/tb_top.sv
module tb_top
    import asl_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic [11:0] aw_addr = 12'h000;
    logic [11:0] ar_addr = 12'h000;
    logic [31:0] w_data = 32'h0;
    logic aw_valid = 1'b0;
    logic w_valid = 1'b0;
    logic b_ready = 1'b0;
    logic ar_valid = 1'b0;
    logic r_ready = 1'b0;
    logic [1:0] resync = 2'h0;
    logic aw_ready, w_ready, b_valid, ar_ready, r_valid, link_up, cal_busy, overrange_detect_enable;
    logic sync_se_n, sync_ts_n;
    logic [1:0] b_resp, r_resp;
    logic [31:0] r_data;
    int errors = 0;
    int total_checks = 0;
    int n;

    initial begin
        forever #10 clk_in = ~clk_in;
    end

    asl_top DUT (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
        .s_axi_awaddr_in(aw_addr), .s_axi_awvalid_in(aw_valid), .s_axi_awready_out(aw_ready),
        .s_axi_wdata_in(w_data), .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(w_valid),
        .s_axi_wready_out(w_ready), .s_axi_bresp_out(b_resp), .s_axi_bvalid_out(b_valid),
        .s_axi_bready_in(b_ready), .s_axi_araddr_in(ar_addr), .s_axi_arvalid_in(ar_valid),
        .s_axi_arready_out(ar_ready), .s_axi_rdata_out(r_data), .s_axi_rresp_out(r_resp),
        .s_axi_rvalid_out(r_valid), .s_axi_rready_in(r_ready), .sync_se_n_in(sync_se_n),
        .sync_ts_n_in(sync_ts_n), .link_up_out(link_up), .cal_busy_out(cal_busy),
        .overrange_enable_out(overrange_detect_enable));
    asl_rx_model u_rx (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .resync_in(resync),
        .sync_se_n_out(sync_se_n), .sync_ts_n_out(sync_ts_n));

    // ********
    // Bus tasks
    // ********
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        int k;
        k = 0;
        @(posedge clk_in);
        aw_addr <= a;
        w_data <= d;
        aw_valid <= 1'b1;
        w_valid <= 1'b1;
        b_ready <= 1'b1;
        do begin
            @(posedge clk_in);
            k++;
            if (aw_valid && aw_ready) aw_valid <= 1'b0;
            if (w_valid && w_ready) w_valid <= 1'b0;
        end while (b_valid !== 1'b1 && k < 100);
        b_ready <= 1'b0;
        chk({31'h0, b_valid}, 32'h1);
        chk({30'h0, b_resp}, {30'h0, er});
    endtask

    task automatic rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e,
        input logic [1:0] er);
        int k;
        k = 0;
        @(posedge clk_in);
        ar_addr <= a;
        ar_valid <= 1'b1;
        r_ready <= 1'b1;
        do begin
            @(posedge clk_in);
            k++;
            if (ar_valid && ar_ready) ar_valid <= 1'b0;
        end while (r_valid !== 1'b1 && k < 100);
        r_ready <= 1'b0;
        chk(r_data & m, e);
        chk({30'h0, r_resp}, {30'h0, er});
    endtask

    task automatic wait_on(input int which, input logic lvl, input int lim);
        int k;
        k = 0;
        while (((which == 0) ? link_up : cal_busy) !== lvl && k < lim) begin
            @(posedge clk_in);
            k++;
        end
        chk({31'h0, (which == 0) ? link_up : cal_busy}, {31'h0, lvl});
    endtask

    task final_report;
        $display("Comparisons %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // ********
    // Tests
    // ********
    initial begin
        repeat (2) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        rdc(ASL_OFF_LINK_EN, 32'h1, 32'h1, 2'h0);
        rdc(ASL_OFF_LINK_CFG, 32'h0001ffff, 32'h00001f00, 2'h0);
        chk({31'h0, overrange_detect_enable}, 32'h0);
        wait_on(0, 1'b1, 3000);
        $display("Test reset done");
        wr(ASL_OFF_LINK_EN, 32'h0, 2'h0);
        wr(ASL_OFF_RESET, 32'h1, 2'h0);
        rdc(ASL_OFF_RESET, 32'h1, 32'h1, 2'h0);
        wr(ASL_OFF_CAL_EN, 32'h0, 2'h0);
        repeat (ASL_SRST_CYC) @(posedge clk_in);
        rdc(ASL_OFF_RESET, 32'h1, 32'h0, 2'h0);
        rdc(ASL_OFF_LINK_EN, 32'h1, 32'h1, 2'h0);
        rdc(ASL_OFF_CAL_EN, 32'h1, 32'h1, 2'h0);
        $display("Test soft reset done");
        wr(ASL_OFF_LINK_CFG, 32'h00010703, 2'h0);
        rdc(ASL_OFF_LINK_CFG, 32'h0001ffff, 32'h00001f00, 2'h0);
        wr(ASL_OFF_LINK_EN, 32'h0, 2'h0);
        wait_on(0, 1'b0, 10);
        rdc(ASL_OFF_STATUS, 32'h3, 32'h0, 2'h0);
        wr(ASL_OFF_CAL_EN, 32'h0, 2'h0);
        for (int i = 0; i < 32; i++) begin
            wr(ASL_OFF_LINK_CFG, {16'h0001, 8'h0f, 3'h0, i[4:0]}, 2'h0);
            rdc(ASL_OFF_LINK_CFG, 32'h0001ffff, {16'h0001, 8'h0f, 3'h0, i[4:0]}, 2'h0);
        end
        for (int i = 0; i < 4; i++) begin
            wr(ASL_OFF_CAL_CFG, {30'h0, i[1:0]}, 2'h0);
            rdc(ASL_OFF_CAL_CFG, 32'h3, {30'h0, i[1:0]}, 2'h0);
        end
        wr(ASL_OFF_CAL_CFG, 32'h2, 2'h0);
        wr(ASL_OFF_CAL_EN, 32'h1, 2'h0);
        wr(ASL_OFF_CAL_CFG, 32'h1, 2'h0);
        rdc(ASL_OFF_CAL_CFG, 32'h3, 32'h2, 2'h0);
        wr(ASL_OFF_OVR_CFG, 32'h00002a01, 2'h0);
        chk({31'h0, overrange_detect_enable}, 32'h1);
        rdc(ASL_OFF_OVR_CFG, 32'h0000ff01, 32'h00002a01, 2'h0);
        $display("Test configure done");
        wr(ASL_OFF_LINK_EN, 32'h1, 2'h0);
        wait_on(0, 1'b1, 3000);
        resync <= 2'h1;
        @(posedge clk_in);
        resync <= 2'h0;
        repeat (20) @(posedge clk_in);
        chk({31'h0, link_up}, 32'h1);
        resync <= 2'h3;
        @(posedge clk_in);
        resync <= 2'h0;
        wait_on(0, 1'b0, 12);
        wait_on(0, 1'b1, 3000);
        $display("Test link done");
        wr(ASL_OFF_CAL_TRIG, 32'h0, 2'h0);
        wr(ASL_OFF_CAL_TRIG, 32'h1, 2'h0);
        wait_on(1, 1'b1, 10);
        n = 0;
        while (cal_busy === 1'b1 && n < 200) begin
            @(posedge clk_in);
            n++;
        end
        chk(n, ASL_CAL_CYC);
        rdc(ASL_OFF_STATUS, 32'hc, 32'hc, 2'h0);
        wr(ASL_OFF_CAL_TRIG, 32'h1, 2'h0);
        repeat (10) @(posedge clk_in);
        chk({31'h0, cal_busy}, 32'h0);
        $display("Test calibration done");
        rdc(12'h020, 32'hffffffff, 32'h0, 2'h2);
        rdc(12'h006, 32'hffffffff, 32'h0, 2'h2);
        wr(12'h100, 32'h0, 2'h2);
        $display("Test unmapped done");
        final_report;
    end

    initial begin
        #400000;
        errors++;
        final_report;
    end
endmodule
